// ==== uart485_pkg.sv ====
// constants, register map and tx states of the rs485 uart block
// assumes a 100 MHz clock and a classic wishbone register bus
package uart485_pkg;
  // ----------------------------------------
  // clock and serial timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int BAUD = 115200;
  localparam int BAUD_DIV = CLK_MHZ * 1000000 / BAUD;
  localparam int RX_MID = BAUD_DIV / 2;
  localparam int RST_MIN_NS = 2500;
  localparam int RST_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_MIN_US = 1;
  localparam int HOLD_CYC = HOLD_MIN_US * CLK_MHZ;
  localparam int FRAME_BITS = 9;
  localparam int STRAP_TAKE = 2;
  localparam int STRAP_DONE = 3;
  // ----------------------------------------
  // lead time table, setting and microseconds
  // ----------------------------------------
  localparam int LEAD_N = 11;
  localparam int LEAD_SEL [LEAD_N] =
    '{0, 1, 2, 3, 4, 5, 10, 20, 40, 60, 80};
  localparam int LEAD_US [LEAD_N] =
    '{20, 40, 60, 80, 100, 110, 250, 480, 900, 1300, 1700};
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_TX = 8'h08;
  localparam logic [7:0] ADR_RX = 8'h0C;
  localparam int CTRL_SEL = 0;
  localparam int CTRL_CMD = 1;
  localparam int CTRL_LEAD = 8;
  localparam int ST_ACT = 0;
  localparam int ST_DE = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_TXFULL = 3;
  localparam int ST_RXV = 4;
  localparam int ST_STRAP = 5;
  localparam int ST_PWD = 6;
  localparam int ST_PIN6 = 7;
  localparam int ST_RTS = 8;
  // ----------------------------------------
  // transmit states
  // ----------------------------------------
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_LEAD = 4'b0010,
    TX_SEND = 4'b0100,
    TX_HOLD = 4'b1000
  } tx_state_e;
endpackage : uart485_pkg

// ==== uart485.sv ====
// serial port with rs485 buffer direction control
// assumes classic wishbone master, host on rx/tx, pins from outside
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module uart485 #(
  parameter int CYC_PER_US = uart485_pkg::CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic rts_n_o,
  input wire logic reset_n_i,
  input wire logic power_down_input_i,
  input wire logic line_buffer_strap_n_i,
  input wire logic aux_pin_6_i,
  input wire logic aux_pin_2_i,
  output logic aux_pin_2_o,
  output logic aux_pin_2_oe_o,
  input wire logic aux_pin_4_i,
  output logic aux_pin_4_o,
  output logic aux_pin_4_oe_o,
  input wire logic aux_pin_5_i,
  output logic aux_pin_5_o,
  output logic aux_pin_5_oe_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam logic [8:0] RST_N = 9'(uart485_pkg::RST_CYC);
  localparam logic [15:0] BDIV = 16'(uart485_pkg::BAUD_DIV - 1);
  localparam logic [15:0] BMID = 16'(uart485_pkg::RX_MID);
  localparam logic [17:0] HOLD = 18'(uart485_pkg::HOLD_CYC);
  localparam logic [3:0] NBITS = 4'(uart485_pkg::FRAME_BITS);
  localparam logic [1:0] ST_TAKE = 2'(uart485_pkg::STRAP_TAKE);
  localparam logic [1:0] ST_DONE = 2'(uart485_pkg::STRAP_DONE);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic sel;
    logic cmd;
    logic [7:0] lsel;
    logic [1:0] st_cnt;
    logic st_low;
    logic oe;
    logic de;
    logic txd;
    uart485_pkg::tx_state_e tx;
    logic [8:0] sh;
    logic [3:0] bcnt;
    logic [15:0] bdiv;
    logic [17:0] tmr;
    logic hv;
    logic [7:0] hd;
    logic [1:0] rxs;
    logic rbusy;
    logic [3:0] rcnt;
    logic [15:0] rdiv;
    logic [7:0] rsh;
    logic rxv;
    logic [7:0] rxd;
    logic rts;
    logic [1:0] rps;
    logic [8:0] rc;
    logic [1:0] pds;
    logic [1:0] sts;
    logic [1:0] g6s;
  } state_s;

  localparam state_s RST_S = '{
    txd: 1'b1, rxs: 2'b11, rps: 2'b11, tx: uart485_pkg::TX_IDLE,
    default: '0};

  state_s s_q;
  state_s s_d;
  logic start;
  logic rd_rx;
  state_s p;

  function automatic logic [17:0] lead_cyc(input logic [7:0] v);
    int us;
    us = uart485_pkg::LEAD_US[0];
    for (int i = 0; i < uart485_pkg::LEAD_N; i++)
      if (v >= 8'(uart485_pkg::LEAD_SEL[i]))
        us = uart485_pkg::LEAD_US[i];
    lead_cyc = 18'(us * CYC_PER_US);
  endfunction : lead_cyc

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    p = RST_S;
    s_d = s_q;
    start = 1'b0;
    rd_rx = 1'b0;
    s_d.rps = {s_q.rps[0], reset_n_i};
    s_d.pds = {s_q.pds[0], power_down_input_i};
    s_d.sts = {s_q.sts[0], line_buffer_strap_n_i};
    s_d.g6s = {s_q.g6s[0], aux_pin_6_i};
    s_d.rxs = {s_q.rxs[0], rx_i};
    if (s_q.rps[1])
      s_d.rc = '0;
    else if (s_q.rc != RST_N)
      s_d.rc = s_q.rc + 9'h001;
    if (s_q.st_cnt != ST_DONE)
    begin
      s_d.st_cnt = s_q.st_cnt + 2'h1;
      if (s_q.st_cnt == ST_TAKE)
        s_d.st_low = ~s_q.sts[1];
    end
    // bus slave
    s_d.ack = cyc_i & stb_i & ~s_q.ack;
    s_d.rdat = '0;
    if (s_d.ack)
    begin
      case (adr_i)
        uart485_pkg::ADR_CTRL:
        begin
          s_d.rdat[uart485_pkg::CTRL_SEL] = s_q.sel;
          s_d.rdat[uart485_pkg::CTRL_CMD] = s_q.cmd;
          s_d.rdat[uart485_pkg::CTRL_LEAD +: 8] = s_q.lsel;
          if (we_i && sel_i[0])
          begin
            s_d.sel = dat_i[uart485_pkg::CTRL_SEL];
            s_d.cmd = dat_i[uart485_pkg::CTRL_CMD];
          end
          if (we_i && sel_i[1])
            s_d.lsel = dat_i[uart485_pkg::CTRL_LEAD +: 8];
        end
        uart485_pkg::ADR_STAT:
        begin
          s_d.rdat[uart485_pkg::ST_ACT] = s_q.oe;
          s_d.rdat[uart485_pkg::ST_DE] = s_q.de;
          s_d.rdat[uart485_pkg::ST_BUSY] = s_q.tx != uart485_pkg::TX_IDLE;
          s_d.rdat[uart485_pkg::ST_TXFULL] = s_q.hv;
          s_d.rdat[uart485_pkg::ST_RXV] = s_q.rxv;
          s_d.rdat[uart485_pkg::ST_STRAP] = s_q.st_low;
          s_d.rdat[uart485_pkg::ST_PWD] = s_q.pds[1];
          s_d.rdat[uart485_pkg::ST_PIN6] = s_q.g6s[1];
          s_d.rdat[uart485_pkg::ST_RTS] = s_q.rts;
        end
        uart485_pkg::ADR_TX:
        begin
          if (we_i && sel_i[0] && !s_q.hv)
          begin
            s_d.hv = 1'b1;
            s_d.hd = dat_i[7:0];
          end
        end
        uart485_pkg::ADR_RX:
        begin
          s_d.rdat[7:0] = s_q.rxd;
          rd_rx = ~we_i;
        end
        default:
          s_d.rdat = '0;
      endcase
    end
    // receiver
    if (rd_rx)
      s_d.rxv = 1'b0;
    if (!s_q.rbusy)
    begin
      if (!s_q.rxs[1])
      begin
        s_d.rbusy = 1'b1;
        s_d.rdiv = BMID;
        s_d.rcnt = '0;
      end
    end
    else if (s_q.rdiv != '0)
      s_d.rdiv = s_q.rdiv - 16'h0001;
    else
    begin
      s_d.rdiv = BDIV;
      s_d.rcnt = s_q.rcnt + 4'h1;
      if (s_q.rcnt == '0)
        s_d.rbusy = ~s_q.rxs[1];
      else if (s_q.rcnt != NBITS)
        s_d.rsh = {s_q.rxs[1], s_q.rsh[7:1]};
      else
      begin
        s_d.rbusy = 1'b0;
        if (s_q.rxs[1] && (!s_q.rxv || rd_rx))
        begin
          s_d.rxv = 1'b1;
          s_d.rxd = s_q.rsh;
        end
      end
    end
    // transmitter
    case (s_q.tx)
      uart485_pkg::TX_IDLE:
      begin
        s_d.de = 1'b0;
        // replies take this path only with oe set; others start at once
        if (s_q.hv && s_q.oe)
        begin
          s_d.de = 1'b1;
          s_d.tmr = lead_cyc(s_q.lsel);
          s_d.tx = uart485_pkg::TX_LEAD;
        end
        else if (s_q.hv)
          start = 1'b1;
      end
      uart485_pkg::TX_LEAD:
      begin
        if (s_q.tmr <= 18'h00001)
          start = 1'b1;
        else
          s_d.tmr = s_q.tmr - 18'h00001;
      end
      uart485_pkg::TX_SEND:
      begin
        if (s_q.bdiv != '0)
          s_d.bdiv = s_q.bdiv - 16'h0001;
        else if (s_q.bcnt != '0)
        begin
          s_d.txd = s_q.sh[0];
          s_d.sh = {1'b1, s_q.sh[8:1]};
          s_d.bcnt = s_q.bcnt - 4'h1;
          s_d.bdiv = BDIV;
        end
        else if (s_q.hv)
          start = 1'b1;
        else if (s_q.de)
        begin
          // hold starts at end of stop bit
          s_d.tmr = HOLD;
          s_d.tx = uart485_pkg::TX_HOLD;
        end
        else
          s_d.tx = uart485_pkg::TX_IDLE;
      end
      uart485_pkg::TX_HOLD:
      begin
        if (s_q.hv)
          start = 1'b1;
        else if (s_q.tmr <= 18'h00001)
        begin
          s_d.de = 1'b0;
          s_d.tx = uart485_pkg::TX_IDLE;
        end
        else
          s_d.tmr = s_q.tmr - 18'h00001;
      end
      default:
      begin
        s_d.de = 1'b0;
        s_d.txd = 1'b1;
        s_d.tx = uart485_pkg::TX_IDLE;
      end
    endcase
    if (start)
    begin
      s_d.txd = 1'b0;
      s_d.sh = {1'b1, s_q.hd};
      s_d.hv = 1'b0;
      s_d.bcnt = NBITS;
      s_d.bdiv = BDIV;
      s_d.tx = uart485_pkg::TX_SEND;
    end
    // outputs only with select set and strap low
    s_d.oe = s_d.sel & s_d.st_low;
    s_d.rts = s_d.rxv;
    // held reset pin clears all but strap, syncs, reset count and bus ack/read data
    if (s_q.rc == RST_N)
    begin
      p.ack = s_d.ack;
      p.rdat = s_d.rdat;
      p.st_cnt = s_d.st_cnt;
      p.st_low = s_d.st_low;
      p.rps = s_d.rps;
      p.rc = s_d.rc;
      p.pds = s_d.pds;
      p.sts = s_d.sts;
      p.g6s = s_d.g6s;
      p.rxs = s_d.rxs;
      s_d = p;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // reset leaves data mode selected
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= RST_S;
    else
      s_q <= s_d;
  end

  assign dat_o = s_q.rdat;
  assign ack_o = s_q.ack;
  assign tx_o = s_q.txd;
  assign rts_n_o = s_q.rts;
  // one flop drives every enable pin
  assign aux_pin_2_o = s_q.de;
  assign aux_pin_4_o = s_q.de;
  assign aux_pin_5_o = s_q.de;
  assign aux_pin_2_oe_o = s_q.oe;
  assign aux_pin_4_oe_o = s_q.oe;
  assign aux_pin_5_oe_o = s_q.oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_rts_level: assert property (rts_n_o == s_q.rxv)
    else $error("flow control does not match holding state");
  a_rx_drop: assert property (
    s_q.rxv && !rd_rx |=> $stable(s_q.rxd))
    else $error("held character overwritten");
  a_pin_reset: assert property (
    s_q.rc == RST_N |=> !aux_pin_2_o && tx_o && !s_q.sel)
    else $error("reset pin did not clear logic");
  a_strap_once: assert property (
    s_q.st_cnt == ST_DONE |=> $stable(s_q.st_low))
    else $error("strap level changed after latch");
  a_oe_mode: assert property (
    aux_pin_5_oe_o == (s_q.sel && s_q.st_low))
    else $error("pin direction wrong for mode");
  a_idle_low: assert property (
    s_q.tx == uart485_pkg::TX_IDLE |-> !aux_pin_4_o)
    else $error("enable high while idle");
  a_lead_load: assert property (
    $rose(aux_pin_2_o) |-> s_q.tmr == lead_cyc(s_q.lsel) && tx_o)
    else $error("lead time not loaded");
  a_lead_end: assert property (
    s_q.tx == uart485_pkg::TX_LEAD && s_q.tmr == 18'h00001
    |=> !tx_o && aux_pin_2_o)
    else $error("start bit not at lead end");
  a_hold_min: assert property (
    $fell(aux_pin_2_o) |-> $past(s_q.tx == uart485_pkg::TX_HOLD)
    && $past(s_q.tmr) == 18'h00001)
    else $error("enable released before hold");
  a_hold_entry: assert property (
    $rose(s_q.tx == uart485_pkg::TX_HOLD) |-> s_q.tmr == HOLD && tx_o)
    else $error("hold not started at stop end");

  c_de_rise: cover property ($rose(aux_pin_2_o));
  c_de_fall: cover property ($fell(aux_pin_2_o));
  c_rx_drop: cover property (
    s_q.rbusy && s_q.rcnt == NBITS && s_q.rdiv == '0 && s_q.rxv);
  c_pin_rst: cover property (s_q.rc == RST_N);
endmodule : uart485

// ==== host_model.sv ====
// host side serial model: sends and collects 8N1 frames
// assumes the bench clock and a fixed bit length in clock cycles
`timescale 1ns/1ps
module host_model #(
  parameter int BIT_CYC = 868
) (
  input wire logic clk_i,
  input wire logic tx_i,
  input wire logic rts_n_i,
  output logic rx_o
);
  logic [7:0] got_q = 8'h00;
  int got_n = 0;
  initial rx_o = 1'h1;
  // hold off while flow control high
  task automatic send(input logic [7:0] b, input bit obey);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    while (obey && rts_n_i !== 1'h0)
      @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      rx_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask : send
  // ----------------------------------------
  // frame collector
  // ----------------------------------------
  always
  begin
    @(negedge tx_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_i);
      got_q[i] = tx_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    if (tx_i === 1'h1)
      got_n++;
  end
endmodule : host_model

// ==== test_uart_rs485_direction_control.sv ====
// self-checking bench for the rs485 serial port
// assumes uart485 with CYC_PER_US of 1 and a host model on the line
`timescale 1ns/1ps
module test_uart_rs485_direction_control;
  localparam int UPUS = 1;
  localparam int BIT = 868;
  localparam int HOLD = uart485_pkg::HOLD_CYC;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic we_i = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack_o, rx_i, tx_o, rts_n_o;
  logic reset_n_i = 1'h1;
  logic pwd_i = 1'h0;
  logic strap_n = 1'h0;
  logic pin6_i = 1'h0;
  logic de2, de4, de5, oe2, oe4, oe5;
  logic de_prev = 1'h0;
  time de_t = 0;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  uart485 #(
    .CYC_PER_US(UPUS)
  ) uart485_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rx_i(rx_i), .tx_o(tx_o),
    .rts_n_o(rts_n_o), .reset_n_i(reset_n_i),
    .power_down_input_i(pwd_i), .line_buffer_strap_n_i(strap_n),
    .aux_pin_6_i(pin6_i), .aux_pin_2_i(1'h0), .aux_pin_2_o(de2),
    .aux_pin_2_oe_o(oe2), .aux_pin_4_i(1'h0), .aux_pin_4_o(de4),
    .aux_pin_4_oe_o(oe4), .aux_pin_5_i(1'h0), .aux_pin_5_o(de5),
    .aux_pin_5_oe_o(oe5)
  );

  host_model host_inst (
    .clk_i(clk_i), .tx_i(tx_o), .rts_n_i(rts_n_o), .rx_o(rx_i)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic chk(input logic [31:0] g, e, input string m);
    check_count++;
    if (g !== e)
      fail(m);
  endtask : chk

  task automatic conclude();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    @(posedge clk_i);
    while (ack_o !== 1'h1)
      @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask : wb

  task automatic wait_lv(input int w, input logic v);
    while ((w == 0 ? tx_o : de2) !== v)
      @(posedge clk_i);
  endtask : wait_lv

  always @(posedge clk_i)
  begin
    cycles++;
    if (de2 === 1'h1 && de_prev !== 1'h1)
      de_t = $time;
    de_prev = de2;
    if (de2 !== de4 || de2 !== de5)
      fail("enable pins differ");
    if (cycles == 60000)
    begin
      fail("timeout");
      conclude();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power();
    wb(1'h0, uart485_pkg::ADR_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset value");
    wb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk({tx_o, rts_n_o, de2, oe2, oe4, oe5}, 32'h20, "idle pins");
  endtask : t_power

  task automatic t_status();
    pwd_i <= 1'h1;
    pin6_i <= 1'h1;
    strap_n <= 1'h1;
    repeat (4) @(posedge clk_i);
    wb(1'h0, uart485_pkg::ADR_STAT, 32'h0);
    chk(rd[7:5], 32'h7, "strap pwd pin6");
  endtask : t_status

  task automatic t_burst(input logic [7:0] ctl, lead, input int us,
                         input logic [7:0] b);
    int n;
    int g;
    time t0;
    g = host_inst.got_n;
    wb(1'h1, uart485_pkg::ADR_CTRL, {16'h0, lead, ctl});
    chk({oe2, oe4, oe5, de2}, 32'hE, "pins on select");
    wb(1'h1, uart485_pkg::ADR_TX, {24'h0, b});
    wait_lv(0, 1'h0);
    n = int'(($time - de_t) / 10);
    chk(n >= us * UPUS && n <= us * UPUS + 2, 32'h1, "lead");
    t0 = $time;
    wait_lv(1, 1'h0);
    n = int'(($time - t0) / 10) - 10 * BIT - HOLD;
    chk(n >= 0 && n <= 3, 32'h1, "hold");
    chk(host_inst.got_q, b, "byte sent");
    chk(host_inst.got_n, g + 1, "frame count");
  endtask : t_burst

  task automatic t_plain();
    time t0;
    t0 = de_t;
    wb(1'h1, uart485_pkg::ADR_CTRL, 32'h0);
    chk({oe2, oe4, oe5}, 32'h0, "pins released");
    wb(1'h1, uart485_pkg::ADR_TX, 32'h5A);
    repeat (10 * BIT + 10) @(posedge clk_i);
    chk(de_t == t0, 32'h1, "enable rose unmanaged");
    chk(host_inst.got_q, 32'h5A, "plain byte");
  endtask : t_plain

  task automatic t_receive();
    chk(rts_n_o, 32'h0, "not ready");
    host_inst.send(8'h3C, 1'h1);
    repeat (2) @(posedge clk_i);
    chk(rts_n_o, 32'h1, "full not flagged");
    wb(1'h0, uart485_pkg::ADR_STAT, 32'h0);
    chk({rd[8], rd[4]}, 32'h3, "status full");
    host_inst.send(8'hC3, 1'h0);
    repeat (2) @(posedge clk_i);
    chk(rts_n_o, 32'h1, "full after drop");
    wb(1'h0, uart485_pkg::ADR_RX, 32'h0);
    chk(rd[7:0], 32'h3C, "rx byte");
    repeat (2) @(posedge clk_i);
    chk(rts_n_o, 32'h0, "not freed");
  endtask : t_receive

  task automatic t_pin_reset();
    wb(1'h1, uart485_pkg::ADR_CTRL, 32'h1);
    reset_n_i <= 1'h0;
    repeat (300) @(posedge clk_i);
    reset_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    wb(1'h0, uart485_pkg::ADR_CTRL, 32'h0);
    chk(rd, 32'h0, "pin reset");
  endtask : t_pin_reset

  task automatic t_strap_high();
    rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (5) @(posedge clk_i);
    wb(1'h1, uart485_pkg::ADR_CTRL, 32'h1);
    chk({oe2, oe4, oe5}, 32'h0, "strap high drives");
    wb(1'h0, uart485_pkg::ADR_STAT, 32'h0);
    chk(rd[5], 32'h0, "strap latch");
  endtask : t_strap_high

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (5) @(posedge clk_i);
    t_power();
    t_status();
    t_burst(8'h01, 8'h00, 20, 8'hA5);
    t_burst(8'h03, 8'h07, 110, 8'h96);
    t_plain();
    t_receive();
    t_pin_reset();
    t_strap_high();
    conclude();
  end
endmodule : test_uart_rs485_direction_control
